/* File: sbd_bus_model.sv */
/*
  far side of the system bus: arbiter and a slave with wait states.
  assumes the bench resolves shared wires and pull-ups.
*/
`timescale 1ns/1ps
module sbd_bus_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        req,
  input  wire logic        as_n,
  input  wire logic [15:0] lines,
  input  wire logic [3:0]  wait_cyc,
  output logic             grant,
  output logic             rdy_n,
  output logic      [15:0] rd_word,
  output logic      [15:0] last_wr
);
  logic [3:0] cnt;
  // released lanes show the inverse, never a stale copy
  assign rd_word = as_n ? 16'h5AA5 : 16'hA55A;
  // grant trails request, so it falls once request is gone
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      grant <= 1'b0;
    else
      grant <= req;
  end
  // answer after wait_cyc cycles, held until the strobe ends
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 4'h0;
      rdy_n <= 1'b1;
    end
    else
    begin
      cnt <= as_n ? 4'h0 : cnt + 4'h1;
      rdy_n <= as_n | (cnt < wait_cyc);
    end
  end
  // last word on the lines while strobed and ready, on reads as well as writes
  always_ff @(posedge clk)
  begin
    if (!as_n && !rdy_n)
      last_wr <= lines;
  end
endmodule

/* File: sbd_fifo.sv */
/*
  small flip-flop fifo with valid/ready on both sides.
  assumes one clock and an active low asynchronous reset.
*/
`timescale 1ns/1ps
module sbd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp;
  logic [PW-1:0]    rp;
  logic [PW:0]      cnt;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_chk
    $error("fifo depth must be a power of two, at least 2");
  end

  // honest flags straight from the fill count
  assign in_ready  = (cnt != FULL_CNT);
  assign out_valid = (cnt != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp];

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'b1;
      if (pop)
        rp <= rp + 1'b1;
      if (push && !pop)
        cnt <= cnt + 1'b1;
      else if (pop && !push)
        cnt <= cnt - 1'b1;
    end
  end

  // storage needs no reset
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp] <= in_data;
  end
endmodule

/* File: sbd_master_port.sv */
/*
  system bus side of the adapter: dma bus master (tx, t1..t4 cycles,
  request/grant, release, error) and direct i/o slave handshake.
  assumes all pins synchronous to clk; falling-edge sample points of the
  bus are taken at the rising edge of clk; the testbench resolves wires.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - tx always in cycle steal; burst: first, carry
// - no tx: strobes already asserted in t1
// - tx keeps address top byte on high lines
// - 8-bit: address byte held on high lines t2-t4
// - 8-bit ready mode: pin ignored, driven high
// - grant seen low, request two edges later
// - strobes driven high from first t1/tx
// - chip select ignored while bus owned
// - ready mode: drop request after last t4
// - ack mode: drop request in first t2
// - ack mode: acknowledge release never checked
// - release ignored unless owned; before next cycle
// - release before t1: last; after: one more, but last if still high in t4
// - request dropped in i1; regrant needs grant low
// - bus error: finish transfer, release, halt dma
// - bus error ignored outside dma cycles
// - dma address/length undefined after bus error
// - dio read starts at sample; enable combinational
// - dio write: buffer enable on third edge
// - ready driven high, checked, then released
// - back-to-back interface access delays ready
module sbd_master_port #(
  parameter int ADDR_W     = sbd_pkg::ADDR_W,
  parameter int LEN_W      = sbd_pkg::LEN_W,
  parameter int FIFO_DEPTH = sbd_pkg::FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ready_handshake_mode,
  input  wire logic              bus_8bit,
  input  wire logic              burst_mode,
  input  wire logic              dma_load,
  input  wire logic              dma_to_system,
  input  wire logic [ADDR_W-1:0] dma_addr_in,
  input  wire logic [LEN_W-1:0]  dma_len_in,
  input  wire logic              dma_clear_halt,
  output logic                   dma_busy,
  output logic                   dma_done,
  output logic                   dma_halted,
  input  wire logic              wr_valid,
  output logic                   wr_ready,
  input  wire logic [15:0]       wr_data,
  output logic                   rd_valid,
  output logic      [15:0]       rd_data,
  output logic                   bus_request_out,
  input  wire logic              bus_grant_in,
  output logic                   bus_owned_out,
  input  wire logic              bus_release_in,
  input  wire logic              bus_error_in,
  input  wire logic              ready_acknowledge_n_in,
  output logic                   ready_acknowledge_n_out,
  output logic                   ready_acknowledge_n_oe,
  output logic                   address_strobe_n_out,
  output logic                   upper_byte_strobe_n_out,
  output logic                   lower_byte_strobe_n_out,
  output logic                   strobes_oe,
  input  wire logic [7:0]        high_address_data_lines_in,
  output logic      [7:0]        high_address_data_lines_out,
  output logic                   high_address_data_lines_oe,
  input  wire logic [7:0]        low_address_data_in,
  output logic      [7:0]        low_address_data_out,
  output logic                   low_address_data_oe,
  input  wire logic              byte_high_or_read_write_in,
  output logic                   byte_high_or_read_write_out,
  output logic                   byte_high_or_read_write_oe,
  output logic                   data_buffer_enable_n,
  output logic                   data_buffer_direction,
  input  wire logic              chip_select_n_in,
  input  wire logic              host_read_n,
  input  wire logic              host_write_n,
  input  wire logic [2:0]        host_reg_sel,
  input  wire logic [15:0]       dio_rdata,
  output logic                   dio_read_pulse,
  output logic                   dio_write_pulse,
  output logic      [2:0]        dio_reg,
  output logic      [15:0]       dio_wdata,
  output logic                   dio_byte_high
);
  import sbd_pkg::*;

  if (ADDR_W < 17 || ADDR_W > 24 || LEN_W < 2 || DIO_GAP_CYC > 255)
  begin : g_chk
    $error("address width 17..24, length width 2 or more");
  end

  // address increment and its carry out of the low byte
  function automatic logic carry8(input logic [7:0] lo, input logic b8);
    logic [8:0] s;
    s = {1'b0, lo} + (b8 ? 9'h001 : 9'h002);
    return s[8];
  endfunction

  sbd_bus_t          bst;
  sbd_dio_t          dst;
  logic [ADDR_W-1:0] addr;
  logic [LEN_W-1:0]  len;
  logic [15:0]       wdata_q;
  logic [15:0]       dio_rd_q;
  logic [GAP_W-1:0]  gap_cnt;
  logic [2:0]        wr_edge;
  logic              first;
  logic              carry_pend;
  logic              prev_tx;
  logic              rel_now;
  logic              rel_next;
  logic              err_seen;
  logic              dben_wr;
  logic              fifo_valid;
  logic              fifo_pop;
  logic [15:0]       fifo_data;
  logic              in_xfer;
  logic              want_xfer;
  logic              need_tx;
  logic              last_xfer;
  logic              strobe_on;
  logic              cs_act;
  logic              dben_rd;
  logic              dio_gap_reg;

  // write path buffer; an empty fifo stalls dma toward the system
  sbd_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // decisions of the master sequencer
  assign in_xfer   = (bst == B_TX) || (bst == B_T1) || (bst == B_T2) ||
                     (bst == B_T3) || (bst == B_T4);
  assign want_xfer = (len != '0) && !dma_halted &&
                     (!dma_to_system || fifo_valid);
  assign need_tx   = first || !burst_mode || carry_pend;
  assign last_xfer = (len == 1) || !burst_mode || rel_now || err_seen ||
                     bus_error_in || (dma_to_system && !fifo_valid) ||
                     (bus_release_in && bst == B_T4 && rel_next);
  assign fifo_pop  = (bst == B_T1) && dma_to_system;

  // bus tenure and transfer state machine
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      bst <= B_IDLE;
    else
    begin
      unique case (bst)
        B_IDLE:
          if (want_xfer && !bus_grant_in)
            bst <= B_ARB1;
        B_ARB1:
          bst <= B_ARB2;
        B_ARB2:
          bst <= B_WAIT;
        B_WAIT:
          if (bus_grant_in)
            bst <= B_TX;
        B_TX:
          bst <= B_T1;
        B_T1:
          bst <= B_T2;
        B_T2:
          bst <= B_T3;
        B_T3:
          // error ends the wait whatever ready says; no check of release
          if (!ready_acknowledge_n_in || err_seen || bus_error_in)
            bst <= B_T4;
        B_T4:
          if (last_xfer)
            bst <= B_I1;
          else if (need_tx)
            bst <= B_TX;
          else
            bst <= B_T1;
        B_I1:
          bst <= B_IDLE;
      endcase
    end
  end

  // request and ownership handshake
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_request_out <= 1'b0;
      bus_owned_out   <= 1'b0;
      first           <= 1'b0;
    end
    else
    begin
      if (bst == B_ARB2)
        bus_request_out <= 1'b1;
      else if (bst == B_T1 && first && !ready_handshake_mode)
        bus_request_out <= 1'b0;
      else if (bst == B_T4 && last_xfer && ready_handshake_mode)
        bus_request_out <= 1'b0;
      else if (bst == B_I1)
        bus_request_out <= 1'b0;
      if (bst == B_WAIT && bus_grant_in)
      begin
        bus_owned_out <= 1'b1;
        first         <= 1'b1;
      end
      else if (bst == B_I1)
        bus_owned_out <= 1'b0;
      if (bst == B_T2)
        first <= 1'b0;
    end
  end

  // release bookkeeping: only heard while we own the bus
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rel_now  <= 1'b0;
      rel_next <= 1'b0;
    end
    else if (bst == B_I1 || !bus_owned_out)
    begin
      rel_now  <= 1'b0;
      rel_next <= 1'b0;
    end
    else if (bst == B_T4)
    begin
      rel_now  <= rel_next || bus_release_in;
      rel_next <= 1'b0;
    end
    else if (bus_release_in)
    begin
      if (bst == B_TX)
        rel_now <= 1'b1;
      else
        rel_next <= 1'b1;
    end
  end

  // address, length and error state of the dma channel
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr       <= '0;
      len        <= '0;
      carry_pend <= 1'b0;
      err_seen   <= 1'b0;
      dma_halted <= 1'b0;
      dma_done   <= 1'b0;
    end
    else
    begin
      dma_done <= 1'b0;
      if (dma_load && bst == B_IDLE)
      begin
        addr <= dma_addr_in;
        len  <= dma_len_in;
      end
      else if (bst == B_T4)
      begin
        // contents not trusted by software after a bus error
        addr       <= addr + (bus_8bit ? ADDR_W'(1) : ADDR_W'(2));
        len        <= len - 1'b1;
        carry_pend <= carry8(addr[7:0], bus_8bit);
        dma_done   <= (len == 1);
      end
      if (in_xfer && bus_error_in)
        err_seen <= 1'b1;
      else if (bst == B_I1)
        err_seen <= 1'b0;
      // set wins over the clear from software
      if (bst == B_T4 && (err_seen || bus_error_in))
        dma_halted <= 1'b1;
      else if (dma_clear_halt)
        dma_halted <= 1'b0;
    end
  end

  // data of the current transfer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wdata_q  <= 16'h0000;
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
      prev_tx  <= 1'b0;
    end
    else
    begin
      prev_tx  <= (bst == B_TX);
      rd_valid <= 1'b0;
      if (fifo_pop)
        wdata_q <= fifo_data;
      if (bst == B_T3 && !dma_to_system &&
          (!ready_acknowledge_n_in || err_seen || bus_error_in))
      begin
        rd_data  <= {bus_8bit ? BYTE_ZERO : high_address_data_lines_in,
                     low_address_data_in};
        rd_valid <= 1'b1;
      end
    end
  end

  assign dma_busy = (len != '0) || (bst != B_IDLE);

  // master strobes; driven for the whole tenure, low in t2, t3 and in a t1 without tx
  assign strobe_on = (bst == B_T2) || (bst == B_T3) ||
                     (bst == B_T1 && !prev_tx);
  assign strobes_oe              = bus_owned_out;
  assign address_strobe_n_out    = !strobe_on;
  assign upper_byte_strobe_n_out = !strobe_on;
  assign lower_byte_strobe_n_out = !strobe_on;

  // byte-high / read-write pin
  assign byte_high_or_read_write_oe  = bus_owned_out;
  assign byte_high_or_read_write_out =
    (bus_8bit && ready_handshake_mode) ? 1'b1 :
    (ready_handshake_mode ? 1'b0 : !dma_to_system);
  assign dio_byte_high = !(bus_8bit && ready_handshake_mode) &&
                         !byte_high_or_read_write_in;

  // address/data lines: master phases first, then dio read data
  always_comb
  begin
    high_address_data_lines_out = BYTE_ZERO;
    high_address_data_lines_oe  = 1'b0;
    low_address_data_out        = BYTE_ZERO;
    low_address_data_oe         = 1'b0;
    if (bus_owned_out)
    begin
      if (bst == B_TX)
      begin
        high_address_data_lines_out = 8'(addr[ADDR_W-1:16]);
        high_address_data_lines_oe  = 1'b1;
      end
      else if (bst == B_T1)
      begin
        high_address_data_lines_out = addr[15:8];
        high_address_data_lines_oe  = 1'b1;
        low_address_data_out        = addr[7:0];
        low_address_data_oe         = 1'b1;
      end
      else if (in_xfer)
      begin
        high_address_data_lines_out = bus_8bit ? addr[15:8] :
                                      wdata_q[15:8];
        high_address_data_lines_oe  = bus_8bit || dma_to_system;
        low_address_data_out        = wdata_q[7:0];
        low_address_data_oe         = dma_to_system;
      end
    end
    else if (dst == D_RD || (dst == D_ACK && dben_rd))
    begin
      // 8-bit reads leave the high lines floating
      high_address_data_lines_out = dio_rd_q[15:8];
      high_address_data_lines_oe  = !bus_8bit;
      low_address_data_out        = dio_rd_q[7:0];
      low_address_data_oe         = 1'b1;
    end
  end

  // direct i/o slave: chip select is dead while we own the bus
  assign cs_act = !chip_select_n_in && !bus_owned_out;
  assign dben_rd = cs_act && !host_read_n &&
                   ((dst == D_IDLE && gap_cnt == '0) ||
                    dst == D_RD || dst == D_ACK);
  assign dio_gap_reg = (dio_reg == REG_IF_DATA) || (dio_reg == REG_IF_ADDR);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dst             <= D_IDLE;
      wr_edge         <= 3'h0;
      dben_wr         <= 1'b0;
      dio_rd_q        <= 16'h0000;
      dio_reg         <= 3'h0;
      dio_wdata       <= 16'h0000;
      dio_read_pulse  <= 1'b0;
      dio_write_pulse <= 1'b0;
    end
    else
    begin
      dio_read_pulse  <= 1'b0;
      dio_write_pulse <= 1'b0;
      unique case (dst)
        D_IDLE:
          if (cs_act && gap_cnt == '0 && !host_read_n)
          begin
            dst            <= D_RD;
            dio_rd_q       <= dio_rdata;
            dio_reg        <= host_reg_sel;
            dio_read_pulse <= 1'b1;
          end
          else if (cs_act && gap_cnt == '0 && !host_write_n)
          begin
            dst     <= D_WR;
            dio_reg <= host_reg_sel;
            wr_edge <= 3'h0;
          end
        D_RD:
          dst <= D_ACK;
        D_WR:
        begin
          wr_edge <= wr_edge + 3'h1;
          if (wr_edge + 3'h1 == 3'(WR_DBEN_EDGE))
            dben_wr <= 1'b1;
          if (wr_edge + 3'h1 == 3'(WR_SAMPLE_EDGE))
          begin
            // enable goes away on the same edge that ready goes low so data may be removed
            dben_wr         <= 1'b0;
            dio_wdata       <= {high_address_data_lines_in,
                                low_address_data_in};
            dio_write_pulse <= 1'b1;
            dst             <= D_ACK;
          end
        end
        D_ACK:
          if (!cs_act || (host_read_n && host_write_n))
            dst <= D_HIGH;
        D_HIGH:
          if (ready_acknowledge_n_in)
            dst <= D_IDLE;
        default:
          dst <= D_IDLE;
      endcase
    end
  end

  // hold-off after an access to the interface data/address registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      gap_cnt <= '0;
    else if (dst == D_HIGH && ready_acknowledge_n_in && dio_gap_reg)
      gap_cnt <= GAP_W'(DIO_GAP_CYC);
    else if (gap_cnt != '0)
      gap_cnt <= gap_cnt - 1'b1;
  end

  // ready pin: low to answer, high until seen high, then released
  assign ready_acknowledge_n_oe  = (dst == D_ACK) || (dst == D_HIGH);
  assign ready_acknowledge_n_out = (dst != D_ACK);

  // external transceiver control
  assign data_buffer_enable_n  = !(dben_rd || dben_wr ||
                                   (bus_owned_out && (bst == B_T2 ||
                                    bst == B_T3 || bst == B_T4)));
  assign data_buffer_direction = bus_owned_out ? dma_to_system :
                                 !(cs_act && !host_write_n);
endmodule

/* File: sbd_master_port_assertions.sv */
/*
  port checks for sbd_master_port, bound to every instance.
  assumes one clock and the active low reset of that module.
*/
`timescale 1ns/1ps
module sbd_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ready_handshake_mode,
  input wire logic bus_request_out,
  input wire logic bus_grant_in,
  input wire logic bus_owned_out,
  input wire logic address_strobe_n_out,
  input wire logic upper_byte_strobe_n_out,
  input wire logic lower_byte_strobe_n_out,
  input wire logic ready_acknowledge_n_in,
  input wire logic ready_acknowledge_n_out,
  input wire logic ready_acknowledge_n_oe,
  input wire logic data_buffer_enable_n,
  input wire logic dio_read_pulse,
  input wire logic dio_write_pulse,
  input wire logic dma_halted
);
  logic stb_n;
  // all three strobes idle high
  assign stb_n = address_strobe_n_out & upper_byte_strobe_n_out
    & lower_byte_strobe_n_out;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // grant must have been low before the request rises
  AST_REQ_GRANT_LOW: assert property (
    $rose(bus_request_out) |-> !$past(bus_grant_in, 3))
    else $error("request while grant high");
  // a tenure opens with tx, so strobes stay high until t2
  AST_TX_STROBES: assert property (
    $rose(bus_owned_out) |-> stb_n [*2] ##1 !address_strobe_n_out)
    else $error("strobes wrong at takeover");
  AST_CS_IGNORED: assert property (
    bus_owned_out |-> !dio_read_pulse && !dio_write_pulse)
    else $error("host access while owned");
  AST_ACK_REQ_DROP: assert property (
    !ready_handshake_mode && $rose(bus_owned_out)
      |-> bus_request_out [*2] ##1 !bus_request_out)
    else $error("ack mode request drop");
  AST_I1_REQ_LOW: assert property (
    $fell(bus_owned_out) |-> !$past(bus_request_out))
    else $error("request high in idle exchange");
  AST_WR_ENABLE: assert property (
    dio_write_pulse |-> $past(data_buffer_enable_n, 3)
      && !$past(data_buffer_enable_n, 2)
      && !$past(data_buffer_enable_n) && data_buffer_enable_n)
    else $error("write enable timing");
  AST_RDY_HIGH: assert property (
    $fell(ready_acknowledge_n_oe) |-> $past(ready_acknowledge_n_out)
      && $past(ready_acknowledge_n_in))
    else $error("ready released while low");
  AST_ERR_RELEASE: assert property (
    $rose(dma_halted) |-> ##[0:4] !bus_owned_out)
    else $error("bus kept after error");
  cover property ($rose(dma_halted));
  cover property ($rose(dio_write_pulse));
  cover property (!ready_handshake_mode && $fell(bus_request_out));
endmodule

bind sbd_master_port sbd_chk u_sbd_chk (.*);

/* File: sbd_pkg.sv */
/*
  shared constants and state types for the system bus dma master port.
  assumes a single 40 MHz clock; all users import the whole package.
*/
package sbd_pkg;
  localparam int ADDR_W         = 24;
  localparam int DATA_W         = 16;
  localparam int LEN_W          = 16;
  localparam int FIFO_DEPTH     = 8;
  localparam int CLK_PERIOD_NS  = 25;
  // longest ready delay on back-to-back host register access: 4.9 us
  localparam int DIO_GAP_NS     = 4900;
  // round down, plus one clock period
  localparam int DIO_GAP_CYC    = DIO_GAP_NS / CLK_PERIOD_NS + 1;
  localparam int GAP_W          = 8;
  // rising edges after the write sample point
  localparam int WR_DBEN_EDGE   = 3;
  localparam int WR_SAMPLE_EDGE = 5;
  localparam logic [2:0] REG_IF_DATA = 3'h0;
  localparam logic [2:0] REG_IF_ADDR = 3'h1;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  typedef enum logic [3:0] {
    B_IDLE, B_ARB1, B_ARB2, B_WAIT, B_TX, B_T1, B_T2, B_T3, B_T4, B_I1
  } sbd_bus_t;

  typedef enum logic [2:0] {
    D_IDLE, D_RD, D_WR, D_ACK, D_HIGH
  } sbd_dio_t;
endpackage

/* File: tb_sbd_master_port.sv */
/*
  self-checking bench for sbd_master_port with the bus model.
  assumes the bound checker; wires resolved here from enables.
*/
`timescale 1ns/1ps
module tb_sbd_master_port;
  import sbd_pkg::*;
  logic clk, nrst, ready_handshake_mode, bus_8bit, burst_mode;
  logic dma_load, dma_to_system, dma_clear_halt, dma_busy, dma_done;
  logic dma_halted, wr_valid, wr_ready, rd_valid, bus_request_out;
  logic bus_grant_in, bus_owned_out, bus_release_in, bus_error_in;
  logic ready_acknowledge_n_in, ready_acknowledge_n_out, m_rdy, as_w;
  logic ready_acknowledge_n_oe, address_strobe_n_out, strobes_oe;
  logic upper_byte_strobe_n_out, lower_byte_strobe_n_out;
  logic high_address_data_lines_oe, low_address_data_oe;
  logic byte_high_or_read_write_in, byte_high_or_read_write_out;
  logic byte_high_or_read_write_oe, data_buffer_enable_n;
  logic data_buffer_direction, chip_select_n_in, host_read_n;
  logic host_write_n, dio_read_pulse, dio_write_pulse, dio_byte_high;
  logic [23:0] dma_addr_in;
  logic [15:0] dma_len_in, wr_data, rd_data, dio_rdata, dio_wdata;
  logic [15:0] hd, m_rd, m_wr;
  logic [7:0]  high_address_data_lines_in, high_address_data_lines_out;
  logic [7:0]  low_address_data_in, low_address_data_out;
  logic [2:0]  host_reg_sel, dio_reg;
  logic [3:0]  m_wait;
  logic [4:0]  obs;
  int          err_total = 0, check_count = 0, n, lat, rdv = 0;
  // enabled driver wins, else host writer or far side; pull-ups idle
  assign as_w = strobes_oe ? address_strobe_n_out : 1'b1;
  assign high_address_data_lines_in = high_address_data_lines_oe ?
    high_address_data_lines_out : (host_write_n ? m_rd[15:8] : hd[15:8]);
  assign low_address_data_in = low_address_data_oe ?
    low_address_data_out : (host_write_n ? m_rd[7:0] : hd[7:0]);
  assign ready_acknowledge_n_in = ready_acknowledge_n_oe ?
    ready_acknowledge_n_out : m_rdy;
  assign byte_high_or_read_write_in = byte_high_or_read_write_oe ?
    byte_high_or_read_write_out : 1'b1;
  assign obs = {as_w, ready_acknowledge_n_oe, ready_acknowledge_n_in,
    dma_busy, bus_owned_out};
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (rd_valid === 1'b1)
      rdv = rdv + 1;
  sbd_master_port u_sbd_master_port (.*);
  sbd_bus_model u_sbd_bus_model (.clk(clk), .nrst(nrst),
    .req(bus_request_out), .as_n(as_w), .wait_cyc(m_wait),
    .lines({high_address_data_lines_in, low_address_data_in}),
    .grant(bus_grant_in), .rdy_n(m_rdy), .rd_word(m_rd), .last_wr(m_wr));
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait for one watched signal; running out ends the run
  task automatic wt(input int k, input logic v);
    for (n = 0; n < 600 && obs[k] !== v; n++)
      @(negedge clk);
    if (n == 600)
    begin
      err_total++;
      $display("MISMATCH t=%0t wait ran out", $time);
      give_verdict();
    end
  endtask
  task automatic dstart(input logic ts, input logic [23:0] a,
                        input logic [15:0] l);
    dma_to_system = ts;
    dma_addr_in = a;
    dma_len_in = l;
    dma_load = 1'b1;
    @(negedge clk);
    dma_load = 1'b0;
  endtask
  // valid stays up between words; ready looked at while settled
  task automatic push(input logic [15:0] d);
    wr_data = d;
    wr_valid = 1'b1;
    check(wr_ready, 1'b1);
    @(negedge clk);
  endtask
  // one host register access, strobes held until ready low
  task automatic dio(input logic wr, input logic [2:0] r,
                     input logic [15:0] d);
    hd = d;
    dio_rdata = d;
    host_reg_sel = r;
    chip_select_n_in = 1'b0;
    host_write_n = !wr;
    host_read_n = wr;
    wt(2, 1'b0);
    lat = n;
    if (wr)
      check({dio_reg, dio_wdata}, {r, d});
    else
      check({high_address_data_lines_out, low_address_data_out}, d);
    check({data_buffer_enable_n, data_buffer_direction}, {wr, !wr});
    chip_select_n_in = 1'b1;
    host_write_n = 1'b1;
    host_read_n = 1'b1;
    wt(3, 1'b0);
  endtask
  initial
  begin
    {nrst, burst_mode, bus_8bit, dma_load, dma_to_system} = '0;
    {dma_clear_halt, wr_valid, bus_release_in, bus_error_in} = '0;
    {chip_select_n_in, host_read_n, host_write_n} = '1;
    ready_handshake_mode = 1'b1;
    {dma_addr_in, dma_len_in, wr_data, host_reg_sel} = '0;
    {dio_rdata, hd, m_wait} = '0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    // cycle steal read: tx on each transfer
    dstart(1'b0, 24'h1234FE, 16'h0002);
    wt(0, 1'b1);
    check(high_address_data_lines_out, 8'h12);
    wt(1, 1'b0);
    check({rdv, rd_data}, {8'h02, 16'hA55A});
    // 8-bit burst read, release seen in tx ends that tenure
    bus_8bit = 1'b1;
    burst_mode = 1'b1;
    rdv = 0;
    dstart(1'b0, 24'h000100, 16'h0003);
    wt(0, 1'b1);
    bus_release_in = 1'b1;
    wt(0, 1'b0);
    bus_release_in = 1'b0;
    check(rdv, 1);
    wt(1, 1'b0);
    check({rdv, rd_data[7:0]}, {8'h03, 8'h5A});
    // host accesses; second interface access is held off
    bus_8bit = 1'b0;
    dio(1'b1, REG_IF_DATA, 16'hC3E1);
    dio(1'b0, REG_IF_ADDR, 16'h5A0F);
    check(lat > 100 && lat <= DIO_GAP_CYC + 4, 1'b1);
    dio(1'b0, 3'h2, 16'h0F0F);
    // ack burst write: fifo filled to refusal, slave stalls
    ready_handshake_mode = 1'b0;
    m_wait = 4'h3;
    for (int i = 0; i < 8; i++)
      push(16'h1000 + 16'(i));
    wr_valid = 1'b0;
    check(wr_ready, 1'b0);
    dstart(1'b1, 24'h0000FC, 16'h0008);
    wt(1, 1'b0);
    check({wr_ready, m_wr}, {1'b1, 16'h1007});
    // bus error mid transfer halts system dma
    burst_mode = 1'b0;
    m_wait = 4'h6;
    dstart(1'b0, 24'h004000, 16'h0004);
    wt(4, 1'b0);
    bus_error_in = 1'b1;
    @(negedge clk);
    bus_error_in = 1'b0;
    wt(0, 1'b0);
    check(dma_halted, 1'b1);
    for (n = 0; n < 30 && bus_request_out !== 1'b1; n++)
      @(negedge clk);
    check(bus_request_out, 1'b0);
    give_verdict();
  end
endmodule
